/* File: sim/sfrm_chk.sv */
`timescale 1ns/1ps
`default_nettype none

// Watches bus reads, indirect access and reset values at the map's ports
module sfrm_chk
	import sfrm_pkg::*;
#(
	parameter int ADDR_W = 12
)
(
	input wire logic              clock_i,
	input wire logic              rst_n_i,
	input wire logic              brownout_reset_i,
	input wire logic              watchdog_reset_i,
	input wire logic              master_clear_pin_n_i,
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic              s_axi_arvalid_i,
	input wire logic              s_axi_arready_o,
	input wire logic [31:0]       s_axi_rdata_o,
	input wire logic              s_axi_rvalid_o,
	input wire logic              s_axi_bvalid_o,
	input wire logic [7:0]        dmem_addr_o,
	input wire logic              dmem_wr_o,
	input wire logic [7:0]        dmem_rdata_i,
	input wire logic [12:0]       pc_o,
	input wire logic [7:0]        port_d_dir_o,
	input wire logic [2:0]        port_e_dir_o,
	input wire logic              parallel_slave_select_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	////////////////////////////////////////////////
	// A read taken, and a watchdog pulse ending with no power-up reset beside it
	sequence ar_take;
		s_axi_arvalid_i && s_axi_arready_o;
	endsequence
	sequence wd_end;
		watchdog_reset_i && !brownout_reset_i ##1 !watchdog_reset_i;
	endsequence

	gap_zero_a: assert property (ar_take ##0 (s_axi_araddr_i[9:5] == 5'h03)
		|=> s_axi_rdata_o == 32'h0) else $error("gap read nonzero");
	ind_read_a: assert property (ar_take ##0
		({s_axi_araddr_i[ADDR_W-1:10], s_axi_araddr_i[8:2]} == '0)
		|=> s_axi_rdata_o[7:0] == $past(dmem_rdata_i)) else $error("indirect read wrong");
	ind_pulse_a: assert property (dmem_wr_o |-> $rose(s_axi_bvalid_o) ##1 !dmem_wr_o)
		else $error("indirect write pulse wrong");
	rd_high_a: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
		else $error("upper read bits set");
	por_vals_a: assert property ($rose(rst_n_i) |-> pc_o == 13'h0 && port_d_dir_o == 8'hff)
		else $error("power-up values wrong");
	wd_vals_a: assert property (wd_end |-> pc_o[7:0] == 8'h00 && port_d_dir_o == 8'hff)
		else $error("watchdog values wrong");
	wd_port_e_a: assert property (wd_end |-> port_e_dir_o == 3'h7 && !parallel_slave_select_o)
		else $error("port E after watchdog wrong");
	wd_pointer_a: assert property (watchdog_reset_i && !brownout_reset_i
		|=> $stable(dmem_addr_o)) else $error("pointer lost on watchdog");
	pc_high_a: assert property ($changed(pc_o[12:8]) |-> $rose(s_axi_bvalid_o)
		|| $past(brownout_reset_i) || $past(watchdog_reset_i)
		|| !$past(master_clear_pin_n_i, 2) || !$past(master_clear_pin_n_i, 3))
		else $error("pc high moved alone");
endmodule

bind sfrm_top sfrm_chk #(.ADDR_W(ADDR_W)) u_chk (
	.clock_i, .rst_n_i, .brownout_reset_i, .watchdog_reset_i, .master_clear_pin_n_i,
	.s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o,
	.s_axi_bvalid_o, .dmem_addr_o, .dmem_wr_o, .dmem_rdata_i, .pc_o, .port_d_dir_o,
	.port_e_dir_o, .parallel_slave_select_o
);

`default_nettype wire

/* File: sim/test_special_function_register_map.sv */
`timescale 1ns/1ps
`default_nettype none

module test_special_function_register_map
	import sfrm_pkg::*;
;
	localparam logic [7:0] PV [11] = '{8'hff, 8'h00, 8'h18, 8'h00, 8'h3f, 8'hff, 8'hff,
		8'hff, 8'h07, 8'h00, 8'h00};
	logic        clock_i, rst_n_i, brownout_reset_i, watchdog_reset_i, master_clear_pin_n_i;
	logic [11:0] s_axi_awaddr_i, s_axi_araddr_i;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rv;
	logic [3:0]  s_axi_wstrb_i;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, br, rr;
	logic        s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
	logic        s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
	logic        s_axi_rvalid_o, s_axi_rready_i, dmem_wr_o, bank_select_o;
	logic [7:0]  dmem_addr_o, dmem_wdata_o, dmem_rdata_i, core_options_o;
	logic [7:0]  port_b_dir_o, port_c_dir_o, port_d_dir_o;
	logic        parallel_slave_select_o, input_buffer_full_i, output_buffer_full_i;
	logic        input_overflow_set_i;
	logic [12:0] pc_o;
	logic [5:0]  port_a_dir_o;
	logic [2:0]  port_e_dir_o;
	logic [7:0]  mem [256];
	int          err_count = 0;
	int          compares = 0;

	sfrm_top #(.ADDR_W(12)) u_dut (
		.clock_i, .rst_n_i, .brownout_reset_i, .watchdog_reset_i, .master_clear_pin_n_i,
		.s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
		.s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
		.s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
		.s_axi_rvalid_o, .s_axi_rready_i, .dmem_addr_o, .dmem_wr_o, .dmem_wdata_o,
		.dmem_rdata_i, .pc_o, .bank_select_o, .core_options_o, .port_a_dir_o, .port_b_dir_o,
		.port_c_dir_o, .port_d_dir_o, .port_e_dir_o, .parallel_slave_select_o,
		.input_buffer_full_i, .output_buffer_full_i, .input_overflow_set_i
	);

	////////////////////////////////////////////////
	// Data memory behind the indirect port answers at once
	assign dmem_rdata_i = mem[dmem_addr_o];
	always @(posedge clock_i)
	begin
		if (dmem_wr_o === 1'b1)
			mem[dmem_addr_o] <= dmem_wdata_o;
	end

	initial
	begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	task automatic summarize();
		if (err_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// A hung handshake ends the run here
	initial
	begin
		#100us;
		err_count++;
		summarize();
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	// Each channel holds valid until its own ready is seen high at a rising edge;
	// values read just after the edge are still those the slave sampled
	task automatic wr(input logic [9:0] ix, input logic [7:0] d);
		logic a;
		logic w;
		a = 1'b0;
		w = 1'b0;
		s_axi_awaddr_i <= {ix, 2'h0};
		s_axi_wdata_i <= {24'h0, d};
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		while (!(a && w))
		begin
			@(posedge clock_i);
			if (!a && s_axi_awready_o === 1'b1)
			begin
				a = 1'b1;
				s_axi_awvalid_i <= 1'b0;
			end
			if (!w && s_axi_wready_o === 1'b1)
			begin
				w = 1'b1;
				s_axi_wvalid_i <= 1'b0;
			end
		end
		do
			@(posedge clock_i);
		while (s_axi_bvalid_o !== 1'b1);
		br = s_axi_bresp_o;
		s_axi_bready_i <= 1'b0;
		@(posedge clock_i);
	endtask

	task automatic rd(input logic [9:0] ix);
		s_axi_araddr_i <= {ix, 2'h0};
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		do
			@(posedge clock_i);
		while (s_axi_arready_o !== 1'b1);
		s_axi_arvalid_i <= 1'b0;
		do
			@(posedge clock_i);
		while (s_axi_rvalid_o !== 1'b1);
		rv = s_axi_rdata_o;
		rr = s_axi_rresp_o;
		s_axi_rready_i <= 1'b0;
		@(posedge clock_i);
	endtask

	task automatic rdc(input logic [9:0] ix, input logic [7:0] e);
		rd(ix);
		chk($sformatf("reg %h", ix), {24'h0, e}, rv);
	endtask

	////////////////////////////////////////////////
	// Power-up reset, then the register scenarios in turn
	initial
	begin
		{rst_n_i, brownout_reset_i, watchdog_reset_i, s_axi_awaddr_i, s_axi_awvalid_i} = '0;
		{s_axi_wdata_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_araddr_i, s_axi_arvalid_i} = '0;
		{s_axi_rready_i, input_buffer_full_i, output_buffer_full_i, input_overflow_set_i} = '0;
		master_clear_pin_n_i = 1'b1;
		s_axi_wstrb_i = 4'hf;
		for (int i = 0; i < 256; i++)
			mem[i] = i[7:0] ^ 8'ha5;
		repeat (4) @(posedge clock_i);
		rst_n_i <= 1'b1;
		@(posedge clock_i);
		for (int i = 8'h0e; i < 8'h18; i++)
			rdc(i[9:0], 8'h00);
		for (int i = 0; i < 11; i++)
			rdc(10'h81 + i[9:0], PV[i]);
		chk("dir_a", 32'h3f, {26'h0, port_a_dir_o});
		chk("dir_bc", 32'hffff, {16'h0, port_b_dir_o, port_c_dir_o});
		wr(10'h04, 8'h42);
		rdc(10'h84, 8'h42);
		wr(10'h0a, 8'h15);
		wr(10'h82, 8'h3c);
		chk("pc", 32'h153c, {19'h0, pc_o});
		rdc(10'h8a, 8'h15);
		rdc(10'h02, 8'h3c);
		wr(10'h8b, 8'h81);
		rdc(10'h0b, 8'h81);
		s_axi_wstrb_i <= 4'he;
		wr(10'h8b, 8'h55);
		s_axi_wstrb_i <= 4'hf;
		rdc(10'h8b, 8'h81);
		wr(10'h81, 8'h00);
		rdc(10'h81, 8'h00);
		chk("options", 32'h0, {24'h0, core_options_o});
		rdc(10'h01, 8'h00);
		wr(10'h03, 8'h27);
		rdc(10'h83, 8'h3f);
		chk("bank", 32'h1, {31'h0, bank_select_o});
		for (int i = 8'h18; i < 8'h20; i++)
		begin
			wr(i[9:0], 8'hff);
			rdc(i[9:0], 8'h00);
		end
		wr(10'h104, 8'h99);
		chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, br});
		rd(10'h104);
		chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, rr});
		chk("rdata", 32'h0, rv);
		rdc(10'h84, 8'h42);
		wr(10'h80, 8'h5a);
		chk("mem", 32'h5a, {24'h0, mem[8'h42]});
		wr(10'h84, 8'h43);
		rdc(10'h00, 8'he6);
		wr(10'h84, 8'h42);
		{input_buffer_full_i, output_buffer_full_i, input_overflow_set_i} <= 3'h7;
		@(posedge clock_i);
		input_overflow_set_i <= 1'b0;
		wr(10'h89, 8'h3d);
		rdc(10'h89, 8'hf5);
		chk("dir_e", 32'h5, {29'h0, port_e_dir_o});
		wr(10'h89, 8'h1d);
		rdc(10'h89, 8'hd5);
		chk("psp", 32'h1, {31'h0, parallel_slave_select_o});
		wr(10'h0e, 8'h12);
		wr(10'h11, 8'h34);
		wr(10'h88, 8'h00);
		chk("dir_d", 32'h0, {24'h0, port_d_dir_o});
		// Watchdog keeps pointer and timer1 byte, status keeps only bits 3..0
		{input_buffer_full_i, output_buffer_full_i, watchdog_reset_i} <= 3'h1;
		repeat (2) @(posedge clock_i);
		watchdog_reset_i <= 1'b0;
		@(posedge clock_i);
		rdc(10'h84, 8'h42);
		rdc(10'h0e, 8'h12);
		rdc(10'h11, 8'h00);
		rdc(10'h81, 8'hff);
		rdc(10'h88, 8'hff);
		rdc(10'h83, 8'h0f);
		rdc(10'h89, 8'h07);
		chk("pc", 32'h0, {19'h0, pc_o});
		wr(10'h81, 8'h00);
		master_clear_pin_n_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		master_clear_pin_n_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		rdc(10'h81, 8'hff);
		rdc(10'h84, 8'h42);
		rdc(10'h83, 8'h0f);
		brownout_reset_i <= 1'b1;
		@(posedge clock_i);
		brownout_reset_i <= 1'b0;
		@(posedge clock_i);
		rdc(10'h84, 8'h00);
		rdc(10'h0e, 8'h00);
		rdc(10'h83, 8'h18);
		summarize();
	end
endmodule

`default_nettype wire

/* File: src/sfrm_pkg.sv */
package sfrm_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Index space: an 8-bit register index, byte address is four times the index
	localparam int IDX_LSB = 2;
	localparam int IDX_W   = 8;
	localparam int PC_HI_W = 5;

	// Bank 0 peripheral registers
	localparam logic [7:0] ADR_T1_LOW   = 8'h0e;
	localparam logic [7:0] ADR_T1_HIGH  = 8'h0f;
	localparam logic [7:0] ADR_T1_CTRL  = 8'h10;
	localparam logic [7:0] ADR_T2_COUNT = 8'h11;
	localparam logic [7:0] ADR_T2_CTRL  = 8'h12;
	localparam logic [7:0] ADR_SER_BUF  = 8'h13;
	localparam logic [7:0] ADR_SER_CTRL = 8'h14;
	localparam logic [7:0] ADR_CC_LOW   = 8'h15;
	localparam logic [7:0] ADR_CC_HIGH  = 8'h16;
	localparam logic [7:0] ADR_CC_CTRL  = 8'h17;

	// Bank 1 core and direction registers
	localparam logic [7:0] ADR_INDIRECT = 8'h80;
	localparam logic [7:0] ADR_OPTIONS  = 8'h81;
	localparam logic [7:0] ADR_PC_LOW   = 8'h82;
	localparam logic [7:0] ADR_STATUS   = 8'h83;
	localparam logic [7:0] ADR_POINTER  = 8'h84;
	localparam logic [7:0] ADR_DIR_A    = 8'h85;
	localparam logic [7:0] ADR_DIR_B    = 8'h86;
	localparam logic [7:0] ADR_DIR_C    = 8'h87;
	localparam logic [7:0] ADR_DIR_D    = 8'h88;
	localparam logic [7:0] ADR_PORT_E   = 8'h89;
	localparam logic [7:0] ADR_PC_LATCH = 8'h8a;
	localparam logic [7:0] ADR_IRQ_CTRL = 8'h8b;
	localparam int         BANK_BIT     = 7;

	////////////////////////////////////////////////////////////////////////////////
	// Table of plain storage registers, entry i is bit i of the keep vector
	localparam int PLAIN_N = 18;
	localparam int IX_OPTIONS  = 10;
	localparam int IX_POINTER  = 11;
	localparam int IX_DIR_A    = 12;
	localparam int IX_DIR_B    = 13;
	localparam int IX_DIR_C    = 14;
	localparam int IX_DIR_D    = 15;
	localparam int IX_PC_LATCH = 16;

	localparam logic [7:0] PLAIN_ADR [PLAIN_N] = '{
		ADR_T1_LOW, ADR_T1_HIGH, ADR_T1_CTRL, ADR_T2_COUNT, ADR_T2_CTRL, ADR_SER_BUF,
		ADR_SER_CTRL, ADR_CC_LOW, ADR_CC_HIGH, ADR_CC_CTRL, ADR_OPTIONS, ADR_POINTER,
		ADR_DIR_A, ADR_DIR_B, ADR_DIR_C, ADR_DIR_D, ADR_PC_LATCH, ADR_IRQ_CTRL};
	localparam logic [7:0] PLAIN_MASK [PLAIN_N] = '{
		8'hff, 8'hff, 8'h3f, 8'hff, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff,
		8'h3f, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'h1f, 8'hff};
	localparam logic [7:0] PLAIN_RST [PLAIN_N] = '{
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'hff, 8'h00, 8'h3f, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00};
	// Set bit: value left unchanged by master-clear and watchdog resets
	localparam logic [PLAIN_N-1:0] PLAIN_KEEP = 18'h009a7;

	////////////////////////////////////////////////////////////////////////////////
	// Status register layout
	localparam int ST_BANK     = 5;
	localparam int ST_TIMEOUT  = 4;
	localparam int ST_PWRDOWN  = 3;
	localparam logic [7:0] ST_POR_VAL  = 8'h18;
	localparam logic [7:0] ST_WR_MASK  = 8'he7;
	localparam logic [7:0] ST_OTH_KEEP = 8'h1f;

	// Port E control layout
	localparam int PE_IBF    = 7;
	localparam int PE_OBF    = 6;
	localparam int PE_INPUT_BUFFER_OVERFLOW   = 5;
	localparam int PE_PSP    = 4;
	localparam int PE_DIR_W  = 3;
	localparam logic [7:0] PE_RST_VAL = 8'h07;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: src/sfrm_top.sv */
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module sfrm_top
	import sfrm_pkg::*;
#(
	parameter int ADDR_W = 12
)
(
	input  wire logic              clock_i,
	input  wire logic              rst_n_i,
	input  wire logic              brownout_reset_i,
	input  wire logic              watchdog_reset_i,
	input  wire logic              master_clear_pin_n_i,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input  wire logic              s_axi_awvalid_i,
	output logic                   s_axi_awready_o,
	input  wire logic [31:0]       s_axi_wdata_i,
	input  wire logic [3:0]        s_axi_wstrb_i,
	input  wire logic              s_axi_wvalid_i,
	output logic                   s_axi_wready_o,
	output logic [1:0]             s_axi_bresp_o,
	output logic                   s_axi_bvalid_o,
	input  wire logic              s_axi_bready_i,
	input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input  wire logic              s_axi_arvalid_i,
	output logic                   s_axi_arready_o,
	output logic [31:0]            s_axi_rdata_o,
	output logic [1:0]             s_axi_rresp_o,
	output logic                   s_axi_rvalid_o,
	input  wire logic              s_axi_rready_i,
	output logic [7:0]             dmem_addr_o,
	output logic                   dmem_wr_o,
	output logic [7:0]             dmem_wdata_o,
	input  wire logic [7:0]        dmem_rdata_i,
	output logic [12:0]            pc_o,
	output logic                   bank_select_o,
	output logic [7:0]             core_options_o,
	output logic [5:0]             port_a_dir_o,
	output logic [7:0]             port_b_dir_o,
	output logic [7:0]             port_c_dir_o,
	output logic [7:0]             port_d_dir_o,
	output logic [2:0]             port_e_dir_o,
	output logic                   parallel_slave_select_o,
	input  wire logic              input_buffer_full_i,
	input  wire logic              output_buffer_full_i,
	input  wire logic              input_overflow_set_i
);

	////////////////////////////////////////////////////////////////////////////////
	// Elaboration check: the index must fit inside the bus address
	generate
		if (ADDR_W < IDX_LSB + IDX_W)
		begin : g_chk
			$error("sfrm_top: ADDR_W too small for the register index");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [1:0]             master_clear_pin_sync;
	logic                   por_rst;
	logic                   oth_rst;
	logic                   aw_held;
	logic [ADDR_W-1:0]      aw_addr;
	logic                   w_held;
	logic [7:0]             w_byte;
	logic                   w_lane;
	logic                   do_wr;
	logic                   wr_hit;
	logic                   wr_en;
	logic [7:0]             wr_idx;
	logic [7:0]             rd_idx;
	logic                   rd_hit;
	logic                   rd_take;
	logic [7:0]             next_rd_byte;
	logic [7:0]             plain [PLAIN_N];
	logic [7:0]             pc_low;
	logic [PC_HI_W-1:0]     pc_high;
	logic [7:0]             status;
	logic [7:0]             port_e;

	////////////////////////////////////////////////////////////////////////////////
	// Fold mirrored core registers onto their bank 1 index
	function automatic logic [7:0] sfrm_fold(input logic [7:0] a);
		logic [6:0] lo;
		lo = a[6:0];
		if (lo == ADR_INDIRECT[6:0] || lo == ADR_PC_LOW[6:0] ||
			lo == ADR_STATUS[6:0] || lo == ADR_POINTER[6:0] ||
			lo == ADR_PC_LATCH[6:0] || lo == ADR_IRQ_CTRL[6:0])
			return {1'b1, lo};
		return a;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Reset classes; the master-clear pin is asynchronous, so it is synchronised
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
			master_clear_pin_sync <= 2'h3;
		else
			master_clear_pin_sync <= {master_clear_pin_sync[0], master_clear_pin_n_i};
	end

	// Brown-out and watchdog come from logic on this clock and need no synchroniser
	// Power-up class wins when both classes are asserted together
	assign por_rst = !rst_n_i || brownout_reset_i;
	assign oth_rst = !master_clear_pin_sync[1] || watchdog_reset_i;

	////////////////////////////////////////////////////////////////////////////////
	// Write address and data channels, taken in either order
	// Both halves stay held until the response is out, so two writes at most are in flight
	assign s_axi_awready_o = !aw_held;
	assign s_axi_wready_o  = !w_held;
	assign do_wr  = aw_held && w_held && !s_axi_bvalid_o;
	assign wr_hit = (aw_addr >> (IDX_LSB + IDX_W)) == '0;
	assign wr_idx = sfrm_fold(aw_addr[IDX_LSB +: IDX_W]);
	// Only byte lane 0 carries register data; upper lanes are ignored
	assign wr_en  = do_wr && wr_hit && w_lane;

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end
		else if (s_axi_awvalid_i && !aw_held)
		begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr_i;
		end
		else if (do_wr)
			aw_held <= 1'b0;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			w_held <= 1'b0;
			w_byte <= 8'h00;
			w_lane <= 1'b0;
		end
		else if (s_axi_wvalid_i && !w_held)
		begin
			w_held <= 1'b1;
			w_byte <= s_axi_wdata_i[7:0];
			w_lane <= s_axi_wstrb_i[0];
		end
		else if (do_wr)
			w_held <= 1'b0;
	end

	// Write response, one cycle after both halves are held
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= RESP_OKAY;
		end
		else if (do_wr)
		begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready_i)
			s_axi_bvalid_o <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Plain storage registers, one per table entry
	generate
		for (genvar i = 0; i < PLAIN_N; i++)
		begin : g_plain
			always_ff @(posedge clock_i)
			begin
				if (por_rst)
					plain[i] <= PLAIN_RST[i] & PLAIN_MASK[i];
				else if (oth_rst)
				begin
					// Keep-class entries hold their value, like the pointer
					if (!PLAIN_KEEP[i])
						plain[i] <= PLAIN_RST[i] & PLAIN_MASK[i];
				end
				else if (wr_en && wr_idx == PLAIN_ADR[i])
					plain[i] <= w_byte & PLAIN_MASK[i];
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Program counter: a low-byte write pulls the latch into the high bits
	// Software may load the latch well ahead; the high bits only move with the low byte,
	// so a computed jump never runs through a half-updated address
	always_ff @(posedge clock_i)
	begin
		if (por_rst || oth_rst)
		begin
			pc_low  <= 8'h00;
			pc_high <= '0;
		end
		else if (wr_en && wr_idx == ADR_PC_LOW)
		begin
			pc_low  <= w_byte;
			pc_high <= plain[IX_PC_LATCH][PC_HI_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status: timeout and power-down flags are read-only from the bus
	// They record why the core last stopped, so software must not be able to fake them
	always_ff @(posedge clock_i)
	begin
		if (por_rst)
			status <= ST_POR_VAL;
		else if (oth_rst)
		begin
			status <= status & ST_OTH_KEEP;
			// A watchdog reset marks the timeout, a master clear leaves it
			if (watchdog_reset_i)
				status[ST_TIMEOUT] <= 1'b0;
		end
		else if (wr_en && wr_idx == ADR_STATUS)
			status <= (w_byte & ST_WR_MASK) | (status & ~ST_WR_MASK);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Port E control: buffer flags follow the slave port, overflow is sticky
	always_ff @(posedge clock_i)
	begin
		if (por_rst || oth_rst)
			port_e <= PE_RST_VAL;
		else
		begin
			port_e[PE_IBF] <= input_buffer_full_i;
			port_e[PE_OBF] <= output_buffer_full_i;
			if (wr_en && wr_idx == ADR_PORT_E)
			begin
				port_e[PE_PSP]          <= w_byte[PE_PSP];
				port_e[PE_DIR_W-1:0]    <= w_byte[PE_DIR_W-1:0];
				// Software may only clear overflow; a new overflow wins
				port_e[PE_INPUT_BUFFER_OVERFLOW] <= input_overflow_set_i || (port_e[PE_INPUT_BUFFER_OVERFLOW] && w_byte[PE_INPUT_BUFFER_OVERFLOW]);
			end
			else if (input_overflow_set_i)
				port_e[PE_INPUT_BUFFER_OVERFLOW] <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Indirect port: no storage, the write goes out to data memory
	assign dmem_addr_o = plain[IX_POINTER];

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			dmem_wr_o    <= 1'b0;
			dmem_wdata_o <= 8'h00;
		end
		else
		begin
			dmem_wr_o <= wr_en && wr_idx == ADR_INDIRECT;
			if (wr_en && wr_idx == ADR_INDIRECT)
				dmem_wdata_o <= w_byte;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read decode; anything unmapped, including 18h..1Fh, reads as zero
	assign s_axi_arready_o = !s_axi_rvalid_o;
	assign rd_take = s_axi_arvalid_i && !s_axi_rvalid_o;
	assign rd_hit  = (s_axi_araddr_i >> (IDX_LSB + IDX_W)) == '0;
	assign rd_idx  = sfrm_fold(s_axi_araddr_i[IDX_LSB +: IDX_W]);

	always_comb
	begin
		next_rd_byte = 8'h00;
		for (int i = 0; i < PLAIN_N; i++)
		begin
			if (rd_idx == PLAIN_ADR[i])
				next_rd_byte = plain[i];
		end
		// Registers outside the table override the loop result
		unique case (rd_idx)
			ADR_INDIRECT: next_rd_byte = dmem_rdata_i;
			ADR_PC_LOW:   next_rd_byte = pc_low;
			ADR_STATUS:   next_rd_byte = status;
			ADR_PORT_E:   next_rd_byte = port_e;
			default:      ;
		endcase
		if (!rd_hit)
			next_rd_byte = 8'h00;
	end

	// Read data is captured at the address handshake
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o  <= 32'h0000_0000;
			s_axi_rresp_o  <= RESP_OKAY;
		end
		else if (rd_take)
		begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o  <= {24'h00_0000, next_rd_byte};
			s_axi_rresp_o  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rready_i)
			s_axi_rvalid_o <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register contents that steer the rest of the core
	assign pc_o                    = {pc_high, pc_low};
	assign bank_select_o           = status[ST_BANK];
	assign core_options_o          = plain[IX_OPTIONS];
	assign port_a_dir_o            = plain[IX_DIR_A][5:0];
	assign port_b_dir_o            = plain[IX_DIR_B];
	assign port_c_dir_o            = plain[IX_DIR_C];
	assign port_d_dir_o            = plain[IX_DIR_D];
	assign port_e_dir_o            = port_e[PE_DIR_W-1:0];
	assign parallel_slave_select_o = port_e[PE_PSP];

endmodule

`default_nettype wire
